// *** core/spmf_consts.svh ***
`ifndef SPMF_CONSTS_SVH
`define SPMF_CONSTS_SVH
// Register byte addresses
`define SPMF_ADDR_DELAY 8'h00
`define SPMF_ADDR_NODE 8'h04
`define SPMF_ADDR_CODES 8'h08
`define SPMF_ADDR_PORT 8'h0C
`define SPMF_ADDR_STAT 8'h10
// Field positions
`define SPMF_NODE_LSB 0
`define SPMF_NODE_MSB 7
`define SPMF_SC_LSB 8
`define SPMF_SC_MSB 11
`define SPMF_EC_LSB 12
`define SPMF_EC_MSB 15
`define SPMF_CODE_LSB 0
`define SPMF_CODE_MSB 7
`define SPMF_CNT_LSB 8
`define SPMF_CNT_MSB 15
`define SPMF_EN_LSB 0
`define SPMF_EN_MSB 3
`define SPMF_SLV_BIT 4
`define SPMF_RATE_LSB 16
`define SPMF_RATE_MSB 23
`define SPMF_MODE_LSB 12
`define SPMF_MODE_MSB 15
// Field values
`define SPMF_SC_ON 4'h1
`define SPMF_EN_ON 4'h1
`define SPMF_MODE_RAW 4'h1
`define SPMF_EC_COUNT 4'h0
`define SPMF_EC_CODE 4'h1
`define SPMF_EC_CRLF 4'h2
`define SPMF_CR 8'h0D
`define SPMF_LF 8'h0A
`define SPMF_FULL_CNT 9'h100
`define SPMF_NODE_MAX 8'h31
// Reset values
`define SPMF_RST_WORD 16'h0000
`define SPMF_RST_PORT 32'h0000_0000
// Timing
`define SPMF_CLK_KHZ 100000
`define SPMF_TICK_MS 10
`define SPMF_TICK_CYC (`SPMF_TICK_MS * `SPMF_CLK_KHZ)
// Bit periods in clocks for each rate code
`define SPMF_DIV_1K2 17'h14585
`define SPMF_DIV_2K4 17'h0A2C3
`define SPMF_DIV_4K8 17'h05161
`define SPMF_DIV_9K6 17'h028B1
`define SPMF_DIV_19K2 17'h01458
// Bus responses
`define SPMF_RESP_OK 2'h0
`define SPMF_RESP_ERR 2'h2
`endif

// *** core/spmf_pkg.sv ***
`default_nettype none
package spmf_pkg;
   // Receive framer states
   typedef enum logic [1:0] {RX_HUNT, RX_COLLECT} spmf_rx_t;
   // Transmit delay states
   typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_GO} spmf_tx_t;
endpackage
`default_nettype wire

// *** core/spmf_top.sv ***
`include "spmf_consts.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Small FIFO with registered flags
module spmf_fifo #(
   parameter int W = 9,
   parameter int D = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Fill side
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   // Drain side
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   logic [W-1:0] mem [D]; // Storage
   logic [AW-1:0] wp_q; // Write pointer
   logic [AW-1:0] rp_q; // Read pointer
   logic [AW:0] cnt_q; // Fill level
   logic [AW:0] cnt_d;
   logic push;
   logic pop;

   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rp_q];

   // Next fill level
   always_comb
   begin
      cnt_d = cnt_q;
      if (push & ~pop)
      begin
         cnt_d = cnt_q + 1'b1;
      end
      else if (pop & ~push)
      begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   // Storage write
   always_ff @(posedge clk)
   begin
      if (ce & push)
      begin
         mem[wp_q] <= in_data;
      end
   end

   // Pointers, level and flags
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         in_ready <= 1'b1;
         out_valid <= 1'b0;
      end
      else if (ce)
      begin
         if (push)
         begin
            wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
         end
         if (pop)
         begin
            rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
         end
         cnt_q <= cnt_d;
         in_ready <= (cnt_d != (AW + 1)'(D));
         out_valid <= (cnt_d != '0);
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////
// Serial port message framing core
module spmf_top #(
   parameter int TICK_CYCLES = `SPMF_TICK_CYC,
   parameter int FIFO_DEPTH = 4
) (
   // Clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Received bytes from the line
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   output logic rx_ready,
   // Framed message stream
   output logic m_valid,
   output logic [7:0] m_data,
   output logic m_last,
   input wire logic m_ready,
   // Transmit request and release
   input wire logic tx_req,
   output logic tx_go_q,
   // Port settings to the line logic
   output logic raw_mode_q,
   output logic [7:0] node_id_q,
   output logic [16:0] baud_div_q
);
   logic [15:0] delay_q; // transmit_delay_word
   logic [15:0] node_q; // node_and_framing_word
   logic [15:0] codes_q; // framing_codes_word
   logic [31:0] port_q; // Port setup word
   logic aw_got_q;
   logic [7:0] awaddr_q;
   logic w_got_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   spmf_pkg::spmf_rx_t rx_q; // Framer state
   spmf_pkg::spmf_tx_t tx_q; // Delay state
   logic [8:0] bytes_q; // Bytes in current message
   logic last_cr_q; // Previous byte was CR
   logic [13:0] ticks_q; // Remaining 10 ms ticks
   logic [31:0] sub_q; // Clocks within a tick
   logic baud_bad_q; // Rate code out of range
   logic fifo_in_ready;
   logic [8:0] fifo_out;
   logic take; // Byte accepted from line
   logic keep; // Byte goes to the stream
   logic ends; // Byte closes the message
   logic [8:0] target;
   logic wr_fire;

   // Apply byte strobes to a 16-bit word
   function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [31:0] d, input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   // Four BCD digits to binary
   function automatic logic [13:0] bcd4(input logic [15:0] b);
      bcd4 = 14'(b[15:12] * 14'd1000 + b[11:8] * 14'd100
         + b[7:4] * 14'd10 + b[3:0]);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Effective mode: honoured only while setup is enabled
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         raw_mode_q <= 1'b0;
      end
      else if (ce)
      begin
         raw_mode_q <= (port_q[`SPMF_EN_MSB:`SPMF_EN_LSB] == `SPMF_EN_ON)
            && (port_q[`SPMF_MODE_MSB:`SPMF_MODE_LSB] == `SPMF_MODE_RAW);
      end
   end

   // Node number, clamped at the top legal BCD value
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         node_id_q <= 8'h00;
      end
      else if (ce)
      begin
         node_id_q <= (node_q[`SPMF_NODE_MSB:`SPMF_NODE_LSB] > `SPMF_NODE_MAX)
            ? `SPMF_NODE_MAX : node_q[`SPMF_NODE_MSB:`SPMF_NODE_LSB];
      end
   end

   // Bit period from rate code
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         baud_div_q <= `SPMF_DIV_1K2;
         baud_bad_q <= 1'b0;
      end
      else if (ce)
      begin
         baud_bad_q <= 1'b0;
         case (port_q[`SPMF_RATE_MSB:`SPMF_RATE_LSB])
            8'h00: baud_div_q <= `SPMF_DIV_1K2;
            8'h01: baud_div_q <= `SPMF_DIV_2K4;
            8'h02: baud_div_q <= `SPMF_DIV_4K8;
            8'h03: baud_div_q <= `SPMF_DIV_9K6;
            8'h04: baud_div_q <= `SPMF_DIV_19K2;
            default:
            begin
               // Unknown code falls back to the slowest rate
               baud_div_q <= `SPMF_DIV_1K2;
               baud_bad_q <= 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive framing
   assign take = rx_valid & fifo_in_ready;
   assign target = (codes_q[`SPMF_CNT_MSB:`SPMF_CNT_LSB] == 8'h00)
      ? `SPMF_FULL_CNT : {1'b0, codes_q[`SPMF_CNT_MSB:`SPMF_CNT_LSB]};
   assign keep = take & (!raw_mode_q || rx_q == spmf_pkg::RX_COLLECT);

   // End-of-message decision for the byte being kept
   always_comb
   begin
      ends = 1'b0;
      if (raw_mode_q)
      begin
         case (node_q[`SPMF_EC_MSB:`SPMF_EC_LSB])
            `SPMF_EC_COUNT: ends = (bytes_q + 9'h001 == target);
            `SPMF_EC_CODE:
               ends = (rx_data == codes_q[`SPMF_CNT_MSB:`SPMF_CNT_LSB]);
            `SPMF_EC_CRLF: ends = last_cr_q && (rx_data == `SPMF_LF);
            default: ends = 1'b0;
         endcase
      end
   end

   // Framer state: hunt for start code, then collect
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rx_q <= spmf_pkg::RX_HUNT;
         bytes_q <= 9'h000;
         last_cr_q <= 1'b0;
      end
      else if (ce && take)
      begin
         if (!raw_mode_q)
         begin
            // Host command traffic passes unframed
            rx_q <= spmf_pkg::RX_HUNT;
            bytes_q <= 9'h000;
            last_cr_q <= 1'b0;
         end
         else if (rx_q == spmf_pkg::RX_HUNT)
         begin
            if (node_q[`SPMF_SC_MSB:`SPMF_SC_LSB] != `SPMF_SC_ON)
            begin
               // No start code: this byte opens the message
               rx_q <= ends ? spmf_pkg::RX_HUNT : spmf_pkg::RX_COLLECT;
               bytes_q <= ends ? 9'h000 : 9'h001;
               last_cr_q <= (rx_data == `SPMF_CR);
            end
            else if (rx_data == codes_q[`SPMF_CODE_MSB:`SPMF_CODE_LSB])
            begin
               rx_q <= spmf_pkg::RX_COLLECT;
               bytes_q <= 9'h000;
               last_cr_q <= 1'b0;
            end
         end
         else
         begin
            rx_q <= ends ? spmf_pkg::RX_HUNT : spmf_pkg::RX_COLLECT;
            bytes_q <= ends ? 9'h000 : bytes_q + 9'h001;
            last_cr_q <= (rx_data == `SPMF_CR);
         end
      end
   end

   // Start code off: first byte kept
   logic push;
   assign push = raw_mode_q && rx_q == spmf_pkg::RX_HUNT
      && node_q[`SPMF_SC_MSB:`SPMF_SC_LSB] != `SPMF_SC_ON ? take : keep;

   spmf_fifo #(.W(9), .D(FIFO_DEPTH)) u_fifo (
      .clk(aclk),
      .rst_n(aresetn),
      .ce(ce),
      .in_valid(rx_valid & push),
      .in_data({ends, rx_data}),
      .in_ready(fifo_in_ready),
      .out_valid(m_valid),
      .out_data(fifo_out),
      .out_ready(m_ready)
   );
   assign rx_ready = fifo_in_ready;
   assign m_data = fifo_out[7:0];
   assign m_last = fifo_out[8];

   ////////////////////////////////////////////////////////////////////////
   // Transmit delay in 10 ms ticks
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tx_q <= spmf_pkg::TX_IDLE;
         tx_go_q <= 1'b0;
         ticks_q <= 14'h0000;
         sub_q <= 32'h0000_0000;
      end
      else if (ce)
      begin
         case (tx_q)
            spmf_pkg::TX_IDLE:
            begin
               sub_q <= 32'h0000_0000;
               ticks_q <= bcd4(delay_q);
               if (tx_req)
               begin
                  // Delay only in raw or slave-initiated mode
                  if ((raw_mode_q || port_q[`SPMF_SLV_BIT])
                     && delay_q != `SPMF_RST_WORD)
                  begin
                     tx_q <= spmf_pkg::TX_WAIT;
                  end
                  else
                  begin
                     tx_q <= spmf_pkg::TX_GO;
                     tx_go_q <= 1'b1;
                  end
               end
            end
            spmf_pkg::TX_WAIT:
            begin
               if (sub_q == 32'(TICK_CYCLES - 1))
               begin
                  sub_q <= 32'h0000_0000;
                  ticks_q <= ticks_q - 14'h0001;
                  if (ticks_q == 14'h0001)
                  begin
                     tx_q <= spmf_pkg::TX_GO;
                     tx_go_q <= 1'b1;
                  end
               end
               else
               begin
                  sub_q <= sub_q + 32'h0000_0001;
               end
            end
            spmf_pkg::TX_GO:
            begin
               // Release held until requester drops
               if (!tx_req)
               begin
                  tx_q <= spmf_pkg::TX_IDLE;
                  tx_go_q <= 1'b0;
               end
            end
            default: tx_q <= spmf_pkg::TX_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI write channels, taken in either order
   assign wr_fire = aw_got_q & w_got_q & ~s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SPMF_RESP_OK;
      end
      else if (ce)
      begin
         if (s_axi_awvalid & s_axi_awready)
         begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready)
         begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire)
         begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_q[7:2] > `SPMF_ADDR_PORT >> 2)
               ? `SPMF_RESP_ERR : `SPMF_RESP_OK;
         end
         if (s_axi_bvalid & s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Register storage
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         delay_q <= `SPMF_RST_WORD;
         node_q <= `SPMF_RST_WORD;
         codes_q <= `SPMF_RST_WORD;
         port_q <= `SPMF_RST_PORT;
      end
      else if (ce && wr_fire)
      begin
         case ({awaddr_q[7:2], 2'b00})
            `SPMF_ADDR_DELAY: delay_q <= merge16(delay_q, wdata_q, wstrb_q);
            `SPMF_ADDR_NODE: node_q <= merge16(node_q, wdata_q, wstrb_q);
            `SPMF_ADDR_CODES: codes_q <= merge16(codes_q, wdata_q, wstrb_q);
            `SPMF_ADDR_PORT:
            begin
               port_q[15:0] <= merge16(port_q[15:0], wdata_q, wstrb_q);
               if (wstrb_q[2])
               begin
                  port_q[23:16] <= wdata_q[23:16];
               end
            end
            default: ;
         endcase
      end
   end

   // AXI read channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `SPMF_RESP_OK;
      end
      else if (ce)
      begin
         if (s_axi_arvalid & s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `SPMF_RESP_OK;
            case ({s_axi_araddr[7:2], 2'b00})
               `SPMF_ADDR_DELAY: s_axi_rdata <= {16'h0000, delay_q};
               `SPMF_ADDR_NODE: s_axi_rdata <= {16'h0000, node_q};
               `SPMF_ADDR_CODES: s_axi_rdata <= {16'h0000, codes_q};
               `SPMF_ADDR_PORT: s_axi_rdata <= {8'h00, port_q[23:0]};
               `SPMF_ADDR_STAT:
                  s_axi_rdata <= {16'h0000, raw_mode_q, baud_bad_q,
                     tx_go_q, tx_q != spmf_pkg::TX_IDLE,
                     rx_q == spmf_pkg::RX_COLLECT, 2'b00, bytes_q};
               default:
               begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `SPMF_RESP_ERR;
               end
            endcase
         end
         if (s_axi_rvalid & s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// *** testbench/spmf_monitor.sv ***
`include "spmf_consts.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Port checker
module spmf_monitor (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Message stream
   input wire logic m_valid,
   input wire logic [7:0] m_data,
   input wire logic m_last,
   input wire logic m_ready,
   // Transmit and port settings
   input wire logic tx_req,
   input wire logic tx_go_q,
   input wire logic [7:0] node_id_q,
   input wire logic [16:0] baud_div_q
);
   // One clock domain, reset masks all checks
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Both write halves taken at one edge
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // Read address taken
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence

   a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
   a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read data late");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
   a_stream_hold: assert property (m_valid && !m_ready |=> m_valid &&
      $stable(m_data) && $stable(m_last)) else $error("stream byte lost");
   a_tx_release: assert property (tx_go_q && !tx_req |=> !tx_go_q)
      else $error("transmit release stuck");
   a_tx_cause: assert property ($rose(tx_go_q) |-> $past(tx_req))
      else $error("transmit without request");
   a_node_clamp: assert property (node_id_q <= `SPMF_NODE_MAX)
      else $error("node number above limit");
   a_rate_table: assert property (baud_div_q inside {`SPMF_DIV_1K2,
      `SPMF_DIV_2K4, `SPMF_DIV_4K8, `SPMF_DIV_9K6, `SPMF_DIV_19K2})
      else $error("bit period off table");
endmodule

bind spmf_top spmf_monitor i_spmf_monitor (.*);
`default_nettype wire

// *** testbench/spmf_peer.sv ***
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Far-side serial party: byte source and slow message sink
module spmf_peer (
   // Clock
   input wire logic aclk,
   // Bytes towards the core
   output logic rx_valid,
   output logic [7:0] rx_data,
   input wire logic rx_ready,
   // Framed bytes from the core
   input wire logic m_valid,
   input wire logic [7:0] m_data,
   input wire logic m_last,
   output logic m_ready,
   // Bench control
   input wire logic stall
);
   logic [8:0] txq[$]; // Bytes still to send
   logic [8:0] got[$]; // Received {last, data}
   logic [1:0] cnt_q; // Slow-accept pacing

   initial
   begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      m_ready = 1'b0;
      cnt_q = 2'h0;
   end

   // Source holds each byte until taken
   always @(posedge aclk)
   begin
      if (rx_valid && rx_ready)
         void'(txq.pop_front());
      if (txq.size() > 0)
      begin
         rx_valid <= 1'b1;
         rx_data <= txq[0][7:0];
      end
      else
      begin
         rx_valid <= 1'b0;
         rx_data <= ~rx_data;
      end
   end

   // Sink takes three cycles in four
   always @(posedge aclk)
   begin
      if (m_valid && m_ready)
         got.push_back({m_last, m_data});
      cnt_q <= cnt_q + 2'h1;
      m_ready <= !stall && cnt_q != 2'h3;
   end
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
`include "spmf_consts.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Bench for the framing core
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef logic [8:0] spmf_bq_t[$]; // Byte list, bit 8 marks last
   localparam int TICK = 4; // Short 10 ms time base
   logic aclk, aresetn, ce, stall;
   logic [7:0] s_axi_awaddr, s_axi_araddr, rx_data, m_data, node_id_q;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed, rd_q, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, rx_valid, rx_ready;
   logic m_valid, m_last, m_ready, tx_req, tx_go_q, raw_mode_q;
   logic [16:0] baud_div_q;
   logic [16:0] div_tab[5] = '{`SPMF_DIV_1K2, `SPMF_DIV_2K4,
      `SPMF_DIV_4K8, `SPMF_DIV_9K6, `SPMF_DIV_19K2};
   logic [7:0] addr_tab[3] = '{`SPMF_ADDR_DELAY, `SPMF_ADDR_NODE,
      `SPMF_ADDR_CODES};
   int n_errors, n_compared, n;

   spmf_top #(.TICK_CYCLES(TICK), .FIFO_DEPTH(4)) i_spmf_top (.*);
   spmf_peer i_spmf_peer (.*);

   // Clock, 10 ns period
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   ////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic spmf_bq_t rbytes(int k);
      spmf_bq_t q;
      repeat (k) q.push_back({1'b0, 8'(rnd())});
      return q;
   endfunction
   // Expected stream
   function automatic spmf_bq_t model(spmf_bq_t in, logic raw,
      logic [15:0] nf, logic [15:0] cw);
      spmf_bq_t o;
      logic hunt, last;
      logic [7:0] b, p;
      int k, lim;
      hunt = raw && nf[11:8] == 4'h1;
      lim = (cw[15:8] == 8'h00) ? 256 : int'(cw[15:8]);
      k = 0;
      p = 8'h00;
      foreach (in[i])
      begin
         b = in[i][7:0];
         if (hunt)
            hunt = (b != cw[7:0]);
         else
         begin
            k++;
            case (nf[15:12])
               4'h0: last = raw && k == lim;
               4'h1: last = raw && b == cw[15:8];
               4'h2: last = raw && p == `SPMF_CR && b == `SPMF_LF;
               default: last = 1'b0;
            endcase
            o.push_back({last, b});
            p = b;
            if (last)
            begin
               k = 0;
               hunt = raw && nf[11:8] == 4'h1;
            end
         end
      end
      return o;
   endfunction
   // BCD delay in cycles
   function automatic int tx_exp(logic [15:0] w, logic on);
      return on ? TICK * (w[15:12] * 1000 + w[11:8] * 100 + w[7:4] * 10
         + w[3:0]) : 0;
   endfunction

   task automatic chkv(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chkt(input int g, input int lo, input int hi);
      n_compared++;
      if (g < lo || g > hi)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t wait %0d not %0d..%0d", $time, g, lo, hi);
      end
   endtask
   task automatic finish_test();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic rst(input int k);
      aresetn <= 1'b0;
      repeat (k) @(posedge aclk);
      aresetn <= 1'b1;
   endtask
   // Register write
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int k;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      k = 0;
      do
      begin
         @(posedge aclk);
         k++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && k < 200);
      if (k >= 200) n_errors++;
      if (k >= 200) finish_test();
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   // Register read into rd_q and resp
   task automatic rd(input logic [7:0] a);
      int k;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      k = 0;
      do
      begin
         @(posedge aclk);
         k++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && k < 200);
      if (k >= 200) n_errors++;
      if (k >= 200) finish_test();
      rd_q = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // Framing run after reset
   task automatic frame(input logic [31:0] port, input logic [15:0] nf,
      input logic [15:0] cw, input spmf_bq_t in, input logic hold);
      spmf_bq_t e;
      logic raw;
      int k;
      rst(2);
      i_spmf_peer.got.delete();
      raw = port[3:0] == `SPMF_EN_ON && port[15:12] == `SPMF_MODE_RAW;
      e = model(in, raw, nf, cw);
      wr(`SPMF_ADDR_PORT, port);
      wr(`SPMF_ADDR_NODE, {16'h0000, nf});
      wr(`SPMF_ADDR_CODES, {16'h0000, cw});
      chkv(raw_mode_q, raw);
      stall <= hold;
      i_spmf_peer.txq = in;
      if (hold)
      begin
         repeat (30) @(posedge aclk);
         chkv(rx_ready, 1'b0); // Full buffer refuses
         stall <= 1'b0;
      end
      k = 0;
      while (i_spmf_peer.got.size() < e.size() && k < 5000)
      begin
         @(posedge aclk);
         k++;
      end
      repeat (10) @(posedge aclk);
      chkv(i_spmf_peer.got.size(), e.size());
      foreach (e[i]) chkv(i_spmf_peer.got[i], e[i]);
   endtask
   // Time from request to release
   task automatic txd(input logic [31:0] port, input logic [15:0] w);
      int k, e;
      wr(`SPMF_ADDR_DELAY, {16'h0000, w});
      wr(`SPMF_ADDR_PORT, port);
      e = tx_exp(w, port[15:12] == `SPMF_MODE_RAW || port[4]);
      tx_req <= 1'b1;
      k = 0;
      do
      begin
         @(posedge aclk);
         k++;
      end while (!tx_go_q && k < 2000);
      chkt(k, e, e + 4);
      tx_req <= 1'b0;
      repeat (2) @(posedge aclk);
      chkv(tx_go_q, 1'b0);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Watchdog
   initial
   begin
      repeat (90000) @(posedge aclk);
      n_errors++;
      finish_test();
   end

   // Main sequence
   initial
   begin
      seed = 32'd7652;
      n_errors = 0;
      n_compared = 0;
      {aresetn, ce, stall, tx_req} = 4'h4;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hF;
      rst(12);
      for (int i = 0; i < 4; i++)
      begin
         rd(8'(4 * i));
         chkv(rd_q, 32'h0000_0000);
      end
      rd(8'h14);
      chkv(resp, `SPMF_RESP_ERR);
      wr(`SPMF_ADDR_STAT, rnd());
      chkv(resp, `SPMF_RESP_ERR);
      foreach (addr_tab[i])
      begin
         d = rnd() & 32'hFFFF_FF1F;
         wr(addr_tab[i], d);
         rd(addr_tab[i]);
         chkv(rd_q, {16'h0000, d[15:0]});
         if (i == 1) chkv(node_id_q, d[7:0]);
      end
      wr(`SPMF_ADDR_NODE, 32'h0000_0019);
      chkv(node_id_q, 8'h19);
      wr(`SPMF_ADDR_NODE, 32'h0000_0045);
      chkv(node_id_q, `SPMF_NODE_MAX);
      for (int r = 0; r < 5; r++)
      begin
         wr(`SPMF_ADDR_PORT, {8'h00, 8'(r), 16'h0001});
         chkv(baud_div_q, div_tab[r]);
      end
      frame(32'h0001, 16'h1000, 16'h0300, rbytes(8), 1'b1);
      frame(32'h1001, 16'h1107, 16'h5AA5, {rbytes(3), 9'h0A5, rbytes(4),
         9'h05A, rbytes(2), 9'h0A5, rbytes(2), 9'h05A}, 1'b0);
      frame(32'h1001, 16'h0207, 16'h03A5, rbytes(9), 1'b0);
      frame(32'h1001, 16'h0000, 16'h0000, rbytes(260), 1'b0);
      frame(32'h1001, 16'h2000, 16'h0000, {rbytes(5), 9'h00D, 9'h00A,
         rbytes(3), 9'h00D, 9'h00A}, 1'b0);
      frame(32'h1000, 16'h0000, 16'h0300, rbytes(6), 1'b0);
      txd(32'h1001, 16'h0012);
      txd(32'h0011, 16'h0003);
      txd(32'h0001, 16'h0099);
      txd(32'h1001, 16'h0000);
      finish_test();
   end
endmodule
`default_nettype wire
